// >>> bbs_pkg.sv
// Constants, register map and types for the buck-boost fault sequencer
package bbs_pkg;

   // Clock and timing, each time in its own unit
   localparam int unsigned CLK_KHZ          = 20000;
   localparam int unsigned SOFT_START_US    = 260;
   localparam int unsigned SOFT_START_PCT   = 95;
   localparam int unsigned SS_TIMEOUT_MS    = 1;
   localparam int unsigned OCP_TIME_US      = 700;
   localparam int unsigned FAULT_WAIT_MS    = 30;
   localparam int unsigned FSW_KHZ          = 1800;
   localparam int unsigned PFM_OFFSET_MV    = 75;

   // Soft-start reference ramp
   localparam int unsigned REF_W            = 8;
   localparam logic [7:0]  REF_MAX          = 8'hFF;
   localparam int unsigned SS_CYCLES        = SOFT_START_US * CLK_KHZ / 1000;
   localparam int unsigned RAMP_STEP_CYCLES =
      SS_CYCLES * 100 / (SOFT_START_PCT * 255);
   localparam logic [4:0]  RAMP_STEP_LAST   = 5'(RAMP_STEP_CYCLES - 1);

   // Long counts, used as defaults of top-level parameters
   localparam int unsigned TIMER_W          = 20;
   localparam int unsigned SS_TIMEOUT_CYC   = SS_TIMEOUT_MS * CLK_KHZ;
   localparam int unsigned OCP_CYC          = OCP_TIME_US * CLK_KHZ / 1000;
   localparam int unsigned FAULT_WAIT_CYC   = FAULT_WAIT_MS * CLK_KHZ;

   // Switching period and phase split
   localparam int unsigned PWM_PERIOD_CYC   = CLK_KHZ / FSW_KHZ;
   localparam logic [3:0]  PWM_LAST         = 4'(PWM_PERIOD_CYC - 1);
   localparam logic [3:0]  PWM_ON_CYC       = 4'(PWM_PERIOD_CYC / 2);
   localparam logic [3:0]  PHASE_B_START    = 4'(PWM_PERIOD_CYC / 3);
   localparam logic [3:0]  PHASE_C_START    = 4'(2 * PWM_PERIOD_CYC / 3);
   localparam logic [6:0]  PFM_OFFSET       = 7'(PFM_OFFSET_MV);

   // APB register map
   localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
   localparam logic [7:0]  ADDR_STATUS      = 8'h04;
   localparam logic [7:0]  ADDR_FAULT_CAUSE = 8'h08;
   localparam int unsigned CTRL_PASS_BIT    = 0;
   localparam int unsigned CTRL_FIXED_BIT   = 1;
   localparam logic [1:0]  CONTROL_RESET    = 2'h0;
   localparam int unsigned CAUSE_TIMEOUT    = 0;
   localparam int unsigned CAUSE_OCP        = 1;
   localparam int unsigned CAUSE_OTP        = 2;
   localparam int unsigned CAUSE_UNDERVOLTAGE_LOCKOUT       = 3;
   localparam logic [3:0]  CAUSE_RESET      = 4'h0;

   // Synchronised input bit positions
   localparam int unsigned IN_W             = 8;
   localparam int unsigned IN_ENABLE        = 0;
   localparam int unsigned IN_OVER_TEMP     = 1;
   localparam int unsigned IN_CUR_LIMIT     = 2;
   localparam int unsigned IN_UNDERVOLTAGE_LOCKOUT          = 3;
   localparam int unsigned IN_AT_TARGET     = 4;
   localparam int unsigned IN_ABOVE         = 5;
   localparam int unsigned IN_BELOW         = 6;
   localparam int unsigned IN_LIGHT_LOAD    = 7;

   typedef enum logic [1:0]
   {
      BBS_SHUTDOWN   = 2'b00,
      BBS_SOFT_START = 2'b01,
      BBS_RUN        = 2'b11,
      BBS_FAULT      = 2'b10
   } bbs_state_t;

   typedef enum logic [1:0]
   {
      BBS_STAGE_BUCK  = 2'b01,
      BBS_STAGE_BOOST = 2'b10,
      BBS_STAGE_THREE = 2'b11
   } bbs_stage_t;

endpackage

// >>> bbs_fault_sequencer.sv
// Shutdown, soft-start, switch selection and fault sequencing with APB registers
// Functional notes
// - Low enable holds shutdown, bias off, output isolated from input.
// - Registers stay readable and writable during shutdown.
// - Rising enable starts soft-start with a gradually ramped reference.
// - Ramp paced so 95 percent target is near 260 us.
// - Output not at target within 1 ms of soft-start gives fault.
// - Over-temperature shuts down; restart only once die cooled.
// - Low enable switches on the output discharge path.
// - Discharge path stays off in the fault state.
// - Current limit held 700 us continuously gives fault.
// - Over-temperature or undervoltage lockout also gives fault.
// - Fault stops all switching and isolates output from input.
// - Fault waits 30 ms before attempting restart.
// - Power-good released only after soft-start completes successfully.
// - Power-good pulled low on fault, held low throughout fault.
// - Pass-through mode: no switch toggles, output follows input.
// - Pass-through keeps only temperature and lockout faults armed; the code also keeps the soft-start timeout fault armed.
// - Input above target: output bridge fixed, input bridge modulates.
// - Input below target: input bridge fixed, output bridge modulates.
// - Input near target: three-phase buck, boost, reset cycle.
// - Light-load pulse mode raises target by 75 mV.
// - Fixed-frequency mode switches at 1.8 MHz nominal.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
module bbs_fault_sequencer
   import bbs_pkg::*;
#(
   parameter int unsigned SS_TIMEOUT_CYCLES = SS_TIMEOUT_CYC,
   parameter int unsigned OCP_CYCLES        = OCP_CYC,
   parameter int unsigned FAULT_WAIT_CYCLES = FAULT_WAIT_CYC
)
(
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        enable_pin,
   input  wire logic        over_temp_flag,
   input  wire logic        current_limit_flag,
   input  wire logic        undervoltage_lockout,
   input  wire logic        output_at_target,
   input  wire logic        input_above_target,
   input  wire logic        input_below_target,
   input  wire logic        light_load_flag,
   output logic             high_side_input_switch,
   output logic             low_side_input_switch,
   output logic             high_side_output_switch,
   output logic             low_side_output_switch,
   output logic             output_discharge,
   output logic             bias_enable,
   output logic [7:0]       soft_start_ref,
   output logic [6:0]       target_raise_mv,
   output logic             power_good_flag_out,
   output logic             power_good_flag_oe
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
      reg_hit = (addr == offset);
   endfunction

   logic [IN_W-1:0]           in_meta;
   logic [IN_W-1:0]           in_sync;
   bbs_state_t                state;
   bbs_state_t                next_state;
   logic [TIMER_W-1:0]        timer;
   logic [TIMER_W-1:0]        next_timer;
   logic [TIMER_W-1:0]        ocp_count;
   logic [4:0]                step_count;
   logic [3:0]                pwm_count;
   logic                      pfm_pulse;
   logic [1:0]                control;
   logic [3:0]                fault_cause;

   // Raw inputs are asynchronous to the clock
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         in_meta <= '0;
         in_sync <= '0;
      end
      else
      begin
         in_meta <= {light_load_flag, input_below_target, input_above_target,
                     output_at_target, undervoltage_lockout, current_limit_flag,
                     over_temp_flag, enable_pin};
         in_sync <= in_meta;
      end
   end

   wire en_s         = in_sync[IN_ENABLE];
   wire otp_s        = in_sync[IN_OVER_TEMP];
   wire ilim_s       = in_sync[IN_CUR_LIMIT];
   wire undervoltage_lockout_s       = in_sync[IN_UNDERVOLTAGE_LOCKOUT];
   wire at_target_s  = in_sync[IN_AT_TARGET];
   wire above_s      = in_sync[IN_ABOVE];
   wire below_s      = in_sync[IN_BELOW];
   wire light_s      = in_sync[IN_LIGHT_LOAD];
   wire pass_through_mode = control[CTRL_PASS_BIT];
   wire forced_fixed      = control[CTRL_FIXED_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state on every access
   wire access    = psel && penable;
   wire done      = access && pready;
   wire hit_ctrl  = reg_hit(paddr, ADDR_CONTROL);
   wire hit_stat  = reg_hit(paddr, ADDR_STATUS);
   wire hit_fault = reg_hit(paddr, ADDR_FAULT_CAUSE);
   wire mapped    = hit_ctrl || hit_stat || hit_fault;
   wire wr_ctrl   = done && pwrite && hit_ctrl;
   wire wr_fault  = done && pwrite && hit_fault;

   wire [31:0] rd_mux = hit_ctrl  ? {30'h0, control} :
                        hit_stat  ? {26'h0, pfm_pulse, power_good_flag_oe, output_discharge,
                                     pass_through_mode, state} :
                        hit_fault ? {28'h0, fault_cause} : 32'h0;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
         control <= CONTROL_RESET;
      end
      else
      begin
         pready  <= access && !pready;
         prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h0;
         pslverr <= access && !pready && !mapped;
         if (wr_ctrl)
            control <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault detection
   wire ocp_trip   = (ocp_count == TIMER_W'(OCP_CYCLES - 1)) && ilim_s;
   wire ss_timeout = (timer == TIMER_W'(SS_TIMEOUT_CYCLES - 1));
   wire hard_fault = otp_s || undervoltage_lockout_s;
   wire wait_over  = (timer == TIMER_W'(FAULT_WAIT_CYCLES - 1));
   wire ramp_done  = (soft_start_ref == REF_MAX);
   wire step_tick  = (step_count == RAMP_STEP_LAST);
   wire active     = (state == BBS_SOFT_START) || (state == BBS_RUN);
   wire ss_fail    = (state == BBS_SOFT_START) && ss_timeout && !(ramp_done && at_target_s);
   wire fault_now  = active && (hard_fault || ocp_trip || ss_fail);

   // Current limit must stay active without a break; pass-through never counts
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         ocp_count <= '0;
      else if (!active || !ilim_s || pass_through_mode || ocp_trip)
         ocp_count <= '0;
      else
         ocp_count <= ocp_count + 1'b1;
   end

   // Cause bits are sticky; a new cause wins over a write-one clear
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         fault_cause <= CAUSE_RESET;
      else
      begin
         fault_cause <= (fault_cause & ~(wr_fault ? pwdata[3:0] : 4'h0)) |
                        ({undervoltage_lockout_s, otp_s, ocp_trip, ss_fail} & {4{active}});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      next_state = state;
      next_timer = timer + 1'b1;
      unique case (state)
         BBS_SHUTDOWN:
         begin
            next_timer = '0;
            if (en_s)
               next_state = BBS_SOFT_START;
         end
         BBS_SOFT_START:
         begin
            if (fault_now)
            begin
               next_state = BBS_FAULT;
               next_timer = '0;
            end
            else if (ramp_done && at_target_s)
               next_state = BBS_RUN;
         end
         BBS_RUN:
         begin
            next_timer = '0;
            if (fault_now)
               next_state = BBS_FAULT;
         end
         BBS_FAULT:
         begin
            if (wait_over)
            begin
               next_timer = timer;
               if (!hard_fault)
               begin
                  next_state = BBS_SOFT_START;
                  next_timer = '0;
               end
            end
         end
      endcase
      if (!en_s)
      begin
         next_state = BBS_SHUTDOWN;
         next_timer = '0;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= BBS_SHUTDOWN;
         timer <= '0;
      end
      else
      begin
         state <= next_state;
         timer <= next_timer;
      end
   end

   // Reference ramp restarts from zero on every soft-start entry
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         step_count     <= '0;
         soft_start_ref <= '0;
      end
      else if (state == BBS_RUN)
      begin
         step_count     <= '0;
         soft_start_ref <= REF_MAX;
      end
      else if (state != BBS_SOFT_START)
      begin
         step_count     <= '0;
         soft_start_ref <= '0;
      end
      else
      begin
         step_count <= step_tick ? 5'h0 : step_count + 1'b1;
         if (step_tick && !ramp_done)
            soft_start_ref <= soft_start_ref + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power stage selection and switching period
   wire pfm_mode  = light_s && !forced_fixed;
   wire period_end = (pwm_count == PWM_LAST);

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pwm_count <= '0;
         pfm_pulse <= 1'b0;
      end
      else
      begin
         pwm_count <= period_end ? 4'h0 : pwm_count + 1'b1;
         if (period_end)
            pfm_pulse <= pfm_mode && !at_target_s;
      end
   end

   bbs_stage_t stage;
   assign stage = above_s ? BBS_STAGE_BUCK :
                  below_s ? BBS_STAGE_BOOST : BBS_STAGE_THREE;

   wire switching = active && (!pfm_mode || pfm_pulse);
   wire sw_on     = pwm_count < PWM_ON_CYC;
   wire phase_a   = pwm_count < PHASE_B_START;
   wire phase_b   = !phase_a && (pwm_count < PHASE_C_START);
   wire phase_c   = !phase_a && !phase_b;

   logic [3:0] next_gates;  // hi_in, lo_in, hi_out, lo_out
   always_comb
   begin
      next_gates = 4'h0;
      if (active && pass_through_mode)
         next_gates = 4'b1010;
      else if (switching)
      begin
         unique case (stage)
            BBS_STAGE_BUCK:  next_gates = {sw_on, !sw_on, 1'b1, 1'b0};
            BBS_STAGE_BOOST: next_gates = {1'b1, 1'b0, !sw_on, sw_on};
            BBS_STAGE_THREE: next_gates = {phase_a || phase_b, phase_c,
                                           phase_b || phase_c, phase_a};
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         {high_side_input_switch, low_side_input_switch,
          high_side_output_switch, low_side_output_switch} <= 4'h0;
         output_discharge    <= 1'b0;
         bias_enable         <= 1'b0;
         target_raise_mv     <= 7'h0;
         power_good_flag_out <= 1'b0;
         power_good_flag_oe  <= 1'b1;
      end
      else
      begin
         {high_side_input_switch, low_side_input_switch,
          high_side_output_switch, low_side_output_switch} <= next_gates;
         output_discharge    <= (state == BBS_SHUTDOWN);
         bias_enable         <= (state != BBS_SHUTDOWN);
         target_raise_mv     <= (active && pfm_mode) ? PFM_OFFSET : 7'h0;
         power_good_flag_out <= 1'b0;
         power_good_flag_oe  <= (state != BBS_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   wire [3:0] gates = {high_side_input_switch, low_side_input_switch,
                       high_side_output_switch, low_side_output_switch};

   property p_shutdown_isolated;
      (state == BBS_SHUTDOWN) |=> (gates == 4'h0) && output_discharge && !bias_enable;
   endproperty
   a_shutdown_isolated: assert property (p_shutdown_isolated)
      else $error("shutdown does not isolate output");

   property p_write_in_shutdown;
      (state == BBS_SHUTDOWN && wr_ctrl) |=> (control == $past(pwdata[1:0]));
   endproperty
   a_write_in_shutdown: assert property (p_write_in_shutdown)
      else $error("control write lost in shutdown");

   property p_start_ramp;
      (state == BBS_SHUTDOWN && en_s) |=> (state == BBS_SOFT_START) ##1 (soft_start_ref == 8'h0);
   endproperty
   a_start_ramp: assert property (p_start_ramp)
      else $error("enable did not start soft-start from zero");

   property p_ramp_step;
      (state == BBS_SOFT_START && !fault_now && en_s && step_tick && !ramp_done)
         |=> (soft_start_ref == $past(soft_start_ref) + 8'h1);
   endproperty
   a_ramp_step: assert property (p_ramp_step)
      else $error("reference ramp step missing");

   property p_ss_timeout;
      (ss_fail && en_s) |=> (state == BBS_FAULT);
   endproperty
   a_ss_timeout: assert property (p_ss_timeout)
      else $error("soft-start timeout not declared");

   property p_no_discharge_in_fault;
      (state == BBS_FAULT) |=> !output_discharge;
   endproperty
   a_no_discharge_in_fault: assert property (p_no_discharge_in_fault)
      else $error("discharge active in fault");

   property p_ocp_fault;
      (ocp_trip && active && en_s) |=> (state == BBS_FAULT) ##1 power_good_flag_oe;
   endproperty
   a_ocp_fault: assert property (p_ocp_fault)
      else $error("held current limit did not fault");

   property p_fault_quiet;
      (state == BBS_FAULT) |=> (gates == 4'h0);
   endproperty
   a_fault_quiet: assert property (p_fault_quiet)
      else $error("switching during fault");

   sequence s_fault_waiting;
      (state == BBS_FAULT) && !wait_over;
   endsequence
   property p_fault_wait;
      s_fault_waiting |=> (state != BBS_SOFT_START);
   endproperty
   a_fault_wait: assert property (p_fault_wait)
      else $error("restart before fault wait elapsed");

   property p_pg_only_run;
      !power_good_flag_oe |-> ($past(state) == BBS_RUN);
   endproperty
   a_pg_only_run: assert property (p_pg_only_run)
      else $error("power-good released outside run");

   property p_pass_steady;
      (state == BBS_RUN && pass_through_mode) [*2] |=> (gates == 4'b1010);
   endproperty
   a_pass_steady: assert property (p_pass_steady)
      else $error("switch toggles in pass-through");

   property p_pass_no_ocp;
      pass_through_mode |-> (ocp_count == '0) || $past(!pass_through_mode);
   endproperty
   a_pass_no_ocp: assert property (p_pass_no_ocp)
      else $error("current limit counted in pass-through");

endmodule

// >>> bbs_host_model.sv
// Host side model: drives enable and pulls up the power-good line
`timescale 1ns/100ps
module bbs_host_model
(
   input  wire logic clock,
   input  wire logic enable_req,
   input  wire logic power_good_flag_out,
   input  wire logic power_good_flag_oe,
   output logic      enable_pin,
   output wire logic pg_line
);
   // Pull-up wins whenever the device lets go of the line
   assign pg_line = power_good_flag_oe ? power_good_flag_out : 1'b1;

   // Single driver; synchronisers are held in reset until this settles
   always @(posedge clock)
      enable_pin <= enable_req;
endmodule

// >>> bbs_fault_sequencer_tb.sv
// Self-checking bench for the buck-boost fault sequencer
`timescale 1ns/100ps
module bbs_fault_sequencer_tb
   import bbs_pkg::*;
;
   // Long counts cut down so the run stays short
   localparam int          SS_T = 8000;
   localparam int          OCP_T = 50;
   localparam int          FW_T = 400;
   localparam int          RAMP = 255 * RAMP_STEP_CYCLES;
   localparam int          NR = 110 / PWM_PERIOD_CYC;
   localparam logic [32:0] ALL = 33'h1FFFFFFFF;
   logic        clock, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, soft_start_ref;
   logic [31:0] pwdata, prdata;
   logic        enable_req, enable_pin, over_temp_flag, current_limit_flag;
   logic        undervoltage_lockout, output_at_target, input_above_target;
   logic        input_below_target, light_load_flag, output_discharge, bias_enable;
   logic        high_side_input_switch, low_side_input_switch;
   logic        high_side_output_switch, low_side_output_switch;
   logic        power_good_flag_out, power_good_flag_oe;
   logic [6:0]  target_raise_mv;
   wire logic   pg_line;
   logic [65:0] exp_q[$];
   logic [65:0] mon_e;
   int          n_errors = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          t0;

   bbs_fault_sequencer #(.SS_TIMEOUT_CYCLES(SS_T), .OCP_CYCLES(OCP_T),
                         .FAULT_WAIT_CYCLES(FW_T)) dut_u
   (
      .clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .enable_pin, .over_temp_flag, .current_limit_flag,
      .undervoltage_lockout, .output_at_target, .input_above_target,
      .input_below_target, .light_load_flag, .high_side_input_switch,
      .low_side_input_switch, .high_side_output_switch, .low_side_output_switch,
      .output_discharge, .bias_enable, .soft_start_ref, .target_raise_mv,
      .power_good_flag_out, .power_good_flag_oe
   );

   bbs_host_model host_u
   (
      .clock, .enable_req, .power_good_flag_out, .power_good_flag_oe,
      .enable_pin, .pg_line
   );

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   always @(posedge clock)
      cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic to_out();
      n_errors++;
      tally_and_finish();
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Read expectations go on the queue; the monitor below compares them
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] m, input logic [32:0] e);
      int k;
      k = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      exp_q.push_back({m, e});
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
         to_out();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits for power-good level; also bounds the elapsed time from t0
   task automatic wait_oe(input logic v, input int lo, input int hi);
      while (power_good_flag_oe !== v && cyc - t0 < hi)
         @(posedge clock);
      if (power_good_flag_oe !== v)
         to_out();
      chk(33'(cyc - t0 >= lo), 33'h1);
   endtask

   // Gates as {hi_in, lo_in, hi_out, lo_out}: rising count, AND, OR
   task automatic watch(input logic [11:0] e);
      logic [3:0] a, o, g, pv;
      int r;
      a = 4'hF;
      o = 4'h0;
      r = 0;
      pv = {high_side_input_switch, low_side_input_switch,
            high_side_output_switch, low_side_output_switch};
      repeat (110)
      begin
         @(posedge clock);
         g = {high_side_input_switch, low_side_input_switch,
              high_side_output_switch, low_side_output_switch};
         a &= g;
         o |= g;
         r += int'(g[3] && !pv[3]);
         pv = g;
      end
      chk(33'({4'(r), a, o}), 33'(e));
   endtask

   always @(posedge clock)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         mon_e = exp_q.pop_front();
         chk({pslverr, pwrite ? 32'h0 : prdata} & mon_e[65:33], mon_e[32:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] wd;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, enable_req} = '0;
      {over_temp_flag, current_limit_flag, undervoltage_lockout} = '0;
      {output_at_target, input_below_target, light_load_flag} = '0;
      input_above_target = 1'b1;
      void'($urandom(85810));
      tick(10);
      reset <= 1'b0;
      apb(1'b0, ADDR_STATUS, 32'h0, ALL, 33'h18);
      apb(1'b0, 8'h0C, 32'h0, ALL, 33'h100000000);
      wd = $urandom;
      apb(1'b1, ADDR_CONTROL, wd, ALL, 33'h0);
      apb(1'b0, ADDR_CONTROL, 32'h0, ALL, {31'h0, wd[1:0]});
      apb(1'b1, 8'h0C, wd, ALL, 33'h100000000);
      apb(1'b1, ADDR_CONTROL, 32'h0, ALL, 33'h0);
      chk(33'({output_discharge, bias_enable, soft_start_ref, pg_line}), 33'h400);
      watch(12'h000);
      // Start-up: gradual ramp, power-good held until it completes
      output_at_target <= 1'b1;
      enable_req <= 1'b1;
      t0 = cyc;
      tick(2000);
      chk(33'({power_good_flag_oe, output_discharge, bias_enable,
               soft_start_ref > 8'h00 && soft_start_ref < 8'hFF}), 33'hB);
      tick(3200);
      chk(33'(soft_start_ref >= 8'hF2 && soft_start_ref < 8'hFF), 33'h1);
      wait_oe(1'b0, RAMP, 5600);
      chk(33'({pg_line, soft_start_ref}), 33'h1FF);
      watch({4'(NR), 4'b0010, 4'b1110});
      input_above_target <= 1'b0;
      input_below_target <= 1'b1;
      tick(12);
      watch({4'h0, 4'b1000, 4'b1011});
      input_below_target <= 1'b0;
      tick(12);
      watch({4'(NR), 4'b0000, 4'b1111});
      light_load_flag <= 1'b1;
      tick(5);
      chk(33'(target_raise_mv), 33'(PFM_OFFSET));
      apb(1'b1, ADDR_CONTROL, 32'h2, ALL, 33'h0);
      tick(3);
      chk(33'(target_raise_mv), 33'h0);
      apb(1'b1, ADDR_CONTROL, 32'h0, ALL, 33'h0);
      light_load_flag <= 1'b0;
      input_above_target <= 1'b1;
      // Over-current: a short burst is forgiven, a long one is not
      current_limit_flag <= 1'b1;
      tick(OCP_T - 10);
      current_limit_flag <= 1'b0;
      tick(10);
      chk(33'(power_good_flag_oe), 33'h0);
      current_limit_flag <= 1'b1;
      t0 = cyc;
      wait_oe(1'b1, OCP_T, OCP_T + 10);
      t0 = cyc;
      current_limit_flag <= 1'b0;
      chk(33'({output_discharge, pg_line}), 33'h0);
      watch(12'h000);
      apb(1'b0, ADDR_STATUS, 32'h0, 33'h1F, 33'h12);
      apb(1'b0, ADDR_FAULT_CAUSE, 32'h0, ALL, 33'h2);
      apb(1'b1, ADDR_FAULT_CAUSE, 32'h2, ALL, 33'h0);
      apb(1'b0, ADDR_FAULT_CAUSE, 32'h0, ALL, 33'h0);
      wait_oe(1'b0, FW_T + RAMP, FW_T + 5600);
      // Pass-through: switches still, over-current ignored
      apb(1'b1, ADDR_CONTROL, 32'h1, ALL, 33'h0);
      tick(3);
      watch({4'h0, 4'b1010, 4'b1010});
      current_limit_flag <= 1'b1;
      tick(OCP_T + 20);
      chk(33'(power_good_flag_oe), 33'h0);
      current_limit_flag <= 1'b0;
      undervoltage_lockout <= 1'b1;
      t0 = cyc;
      wait_oe(1'b1, 0, 10);
      apb(1'b0, ADDR_FAULT_CAUSE, 32'h0, 33'h8, 33'h8);
      apb(1'b1, ADDR_CONTROL, 32'h0, ALL, 33'h0);
      // Hot die holds the fault past the wait until it cools
      over_temp_flag <= 1'b1;
      undervoltage_lockout <= 1'b0;
      tick(2 * FW_T);
      apb(1'b0, ADDR_STATUS, 32'h0, 33'h3, 33'h2);
      over_temp_flag <= 1'b0;
      tick(20);
      apb(1'b0, ADDR_STATUS, 32'h0, 33'h3, 33'h1);
      enable_req <= 1'b0;
      tick(6);
      chk(33'({output_discharge, bias_enable, pg_line}), 33'h4);
      // Output never reaches target: timeout fault
      output_at_target <= 1'b0;
      enable_req <= 1'b1;
      tick(SS_T - 100);
      apb(1'b0, ADDR_STATUS, 32'h0, 33'h3, 33'h1);
      tick(200);
      apb(1'b0, ADDR_STATUS, 32'h0, 33'h3, 33'h2);
      apb(1'b0, ADDR_FAULT_CAUSE, 32'h0, 33'h1, 33'h1);
      tick(2);
      tally_and_finish();
   end
endmodule
